// >>> logic/i2css_pkg.sv
// shared constants, register map and types of the i2c slave status block
`default_nettype none
package i2css_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_MODULE_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_SLAVE_ADDR = 8'h0C;
  localparam logic [7:0] OFS_TIMEOUT_CTRL = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MODE_LSB = 5;
  localparam int ENABLE_BIT = 1;
  localparam int TO_EN_BIT = 7;
  localparam int TO_FLAG_BIT = 6;
  localparam int ADDR_LSB = 1;
  localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] RST_STATUS_CTRL = 8'h81;
  localparam logic [2:0] RST_MODE = 3'h7;
  localparam logic [6:0] RST_SLAVE_ADDR = 7'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [5:0] RST_TO_SEL = 6'h00;

  // ----------------------------------------
  // counts and timing
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_MHZ = 100;
  // one time-out unit (32 slow-clock periods), in microseconds
  localparam int TO_UNIT_US = 1000;
  localparam int TO_UNIT_CYCLES = TO_UNIT_US * CLK_MHZ;

  // ----------------------------------------
  // status/control register fields, msb first
  // ----------------------------------------
  typedef struct packed {
    logic transfer_complete_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic direction_select;
    logic transmit_ack_bit;
    logic read_write_status;
    logic address_wake_enable;
    logic receive_ack_flag;
  } i2css_status_t;

  // protocol states
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_HOLD = 9'h008,
    ST_RX = 9'h010,
    ST_RACK = 9'h020,
    ST_TX = 9'h040,
    ST_TACK = 9'h080,
    ST_SKIP = 9'h100
  } i2css_state_t;

endpackage
`default_nettype wire

// >>> logic/i2css_sync.sv
// two-flop synchroniser for one bus pin
`timescale 1ns/1ns
`default_nettype none
module i2css_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta;

  // ----------------------------------------
  // two stages, idle level is high
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> logic/i2css_top.sv
// i2c slave: start/stop, address match, byte transfer, scl hold, time-out, wishbone registers
// Contract
// - completion flag low while a byte moves, set with interrupt after eight bits.
// - address match flag high when received address equals stored address.
// - bus busy set on start, cleared on stop.
// - software direction bit 4: 0 receiver, 1 transmitter.
// - after eight received bits, drive transmit ack bit on ninth clock.
// - eighth bit after start captured into read/write flag.
// - read/write flag 1 means master reads, 0 means master writes.
// - wake on address match when wake enable set; firmware clears it.
// - receive ack flag 0 if ack sampled on ninth clock, else 1.
// - transmitter continues while ack seen; on no ack releases sda.
// - first seven bits after start, msb first, form the compared address.
// - address match also raises the interrupt.
// - matching address gets a low acknowledge on the ninth bit.
// - start is sda falling while scl high; slave never drives start.
// - after match, scl held until data register write or dummy read.
// - slave address sits in bits 7..1; bit 0 reads zero.
// - enable rising resets status flags, keeps direction, transmit ack and wake enable bits.
// - bytes are eight bits, msb first.
// - time-out overflow stops counter, clears enable, sets flag, interrupts.
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module i2css_top
  import i2css_pkg::*;
#(
  parameter int TO_TICK_CYCLES = TO_UNIT_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic wake_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  i2css_status_t status;
  i2css_state_t state;
  logic [2:0] mode;
  logic enable, en_q, i2c_on, en_rise;
  logic [6:0] slave_addr;
  logic [7:0] data_reg, shreg;
  logic [3:0] cnt;
  logic to_en, to_flag, to_run, to_ovf;
  logic [5:0] to_sel, to_cnt;
  logic [31:0] div_cnt;
  logic scl_s, sda_s, scl_q, sda_q;
  logic start, stop, scl_rise, scl_fall;
  logic acc, wr_ev, rd_ev, wr_data, rd_data, rel;
  logic addr_hit, rx_done, tx_done, ack_smp, drive_sda;

  // ----------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------
  i2css_sync u_scl_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(scl_i), .q_o(scl_s));
  i2css_sync u_sda_sync (.clk_i(clk_i), .rst_i(rst_i), .d_i(sda_i), .q_o(sda_s));

  // previous synced levels for edge finding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start = i2c_on & scl_s & scl_q & sda_q & ~sda_s;
  assign stop = i2c_on & scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign i2c_on = enable & (mode == MODE_I2C_SLAVE);
  assign en_rise = enable & ~en_q;

  // ----------------------------------------
  // wishbone slave, one wait state
  // ----------------------------------------
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ev = acc & wb_we_i & wb_sel_i[0];
  assign rd_ev = acc & ~wb_we_i;
  assign wr_data = wr_ev & (wb_adr_i == OFS_DATA);
  assign rd_data = rd_ev & (wb_adr_i == OFS_DATA);

  // ack and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (rd_ev)
      begin
        unique case (wb_adr_i)
          OFS_MODULE_CTRL: wb_dat_o[7:0] <= {mode, 3'h0, enable, 1'b0};
          OFS_STATUS_CTRL: wb_dat_o[7:0] <= status;
          OFS_DATA: wb_dat_o[7:0] <= data_reg;
          OFS_SLAVE_ADDR: wb_dat_o[7:0] <= {slave_addr, 1'b0};
          OFS_TIMEOUT_CTRL: wb_dat_o[7:0] <= {to_en, to_flag, to_sel};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // mode, enable and slave address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode <= RST_MODE;
      enable <= 1'b0;
      en_q <= 1'b0;
      slave_addr <= RST_SLAVE_ADDR;
    end
    else
    begin
      en_q <= enable;
      if (wr_ev && wb_adr_i == OFS_MODULE_CTRL)
      begin
        mode <= wb_dat_i[MODE_LSB +: 3];
        enable <= wb_dat_i[ENABLE_BIT];
      end
      if (wr_ev && wb_adr_i == OFS_SLAVE_ADDR)
        slave_addr <= wb_dat_i[ADDR_LSB +: 7];
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  assign rel = (state == ST_HOLD) & ((wr_data & status.direction_select)
             | (rd_data & ~status.direction_select));
  assign addr_hit = (state == ST_ADDR) & scl_fall & (cnt == BITS_PER_BYTE)
                  & (shreg[7:1] == slave_addr);
  assign rx_done = (state == ST_RX) & scl_fall & (cnt == BITS_PER_BYTE);
  assign tx_done = (state == ST_TX) & scl_fall & (cnt == BITS_PER_BYTE - 4'h1);
  assign ack_smp = (state == ST_TACK) & scl_rise;

  // state, bit count and shifter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !i2c_on || to_ovf || stop)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
    end
    else if (start)
    begin
      state <= ST_ADDR;
      cnt <= 4'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall && cnt == BITS_PER_BYTE)
          begin
            if (state == ST_RX)
              state <= ST_RACK;
            else if (addr_hit)
              state <= ST_AACK;
            else
              state <= ST_SKIP;
          end
        end
        ST_AACK, ST_RACK:
          if (scl_fall)
            state <= ST_HOLD;
        ST_HOLD:
        begin
          if (rel)
          begin
            cnt <= 4'h0;
            // the releasing write lands in data_reg on this same edge, so take it from the bus
            shreg <= wr_data ? wb_dat_i[7:0] : data_reg;
            state <= status.direction_select ? ST_TX : ST_RX;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            shreg <= {shreg[6:0], 1'b0};
            cnt <= cnt + 4'h1;
            if (tx_done)
              state <= ST_TACK;
          end
        end
        ST_TACK:
          if (scl_fall)
            state <= status.receive_ack_flag ? ST_SKIP : ST_HOLD;
        ST_SKIP: state <= ST_SKIP;
      endcase
    end
  end

  // received bytes land in the data register, software loads it to send
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_reg <= RST_DATA;
    else if (rx_done)
      data_reg <= shreg;
    else if (wr_data)
      data_reg <= wb_dat_i[7:0];
  end

  // ----------------------------------------
  // status/control register, hardware sets win
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || to_ovf)
      status <= RST_STATUS_CTRL;
    else
    begin
      if (wr_ev && wb_adr_i == OFS_STATUS_CTRL)
      begin
        status.direction_select <= wb_dat_i[4];
        status.transmit_ack_bit <= wb_dat_i[3];
        status.address_wake_enable <= wb_dat_i[1];
      end
      if (en_rise && mode == MODE_I2C_SLAVE)
      begin
        status.transfer_complete_flag <= RST_STATUS_CTRL[7];
        status.address_match_flag <= RST_STATUS_CTRL[6];
        status.bus_busy_flag <= RST_STATUS_CTRL[5];
        status.read_write_status <= RST_STATUS_CTRL[2];
        status.receive_ack_flag <= RST_STATUS_CTRL[0];
      end
      else
      begin
        if (start || rel)
        begin
          status.transfer_complete_flag <= 1'b0;
          status.address_match_flag <= 1'b0;
        end
        if (addr_hit || rx_done || tx_done)
          status.transfer_complete_flag <= 1'b1;
        if (addr_hit)
        begin
          status.address_match_flag <= 1'b1;
          status.read_write_status <= shreg[0];
        end
        if (start)
          status.bus_busy_flag <= 1'b1;
        else if (stop)
          status.bus_busy_flag <= 1'b0;
        if (ack_smp)
          status.receive_ack_flag <= sda_s;
      end
    end
  end

  // ----------------------------------------
  // time-out counter
  // ----------------------------------------
  assign to_ovf = to_run & to_en & (div_cnt == 32'(TO_TICK_CYCLES - 1)) & (to_cnt == to_sel);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      to_run <= 1'b0;
      div_cnt <= 32'h0000_0000;
      to_cnt <= 6'h00;
    end
    else if (stop || to_ovf || !i2c_on)
    begin
      to_run <= 1'b0;
      div_cnt <= 32'h0000_0000;
      to_cnt <= 6'h00;
    end
    else if (start || addr_hit || scl_fall)
    begin
      to_run <= to_run | start | addr_hit;
      div_cnt <= 32'h0000_0000;
      to_cnt <= 6'h00;
    end
    else if (to_run && to_en)
    begin
      if (div_cnt == 32'(TO_TICK_CYCLES - 1))
      begin
        div_cnt <= 32'h0000_0000;
        to_cnt <= to_cnt + 6'h01;
      end
      else
        div_cnt <= div_cnt + 32'h0000_0001;
    end
  end

  // time-out control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      to_en <= 1'b0;
      to_flag <= 1'b0;
      to_sel <= RST_TO_SEL;
    end
    else
    begin
      if (wr_ev && wb_adr_i == OFS_TIMEOUT_CTRL)
      begin
        to_en <= wb_dat_i[TO_EN_BIT];
        to_flag <= wb_dat_i[TO_FLAG_BIT];
        to_sel <= wb_dat_i[5:0];
      end
      if (to_ovf)
      begin
        to_en <= 1'b0;
        to_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pins, interrupt and wake pulses
  // ----------------------------------------
  assign drive_sda = (state == ST_AACK) | ((state == ST_RACK) & ~status.transmit_ack_bit)
                   | ((state == ST_TX) & ~shreg[7]);
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end
    else
    begin
      sda_oe_o <= drive_sda & i2c_on;
      scl_oe_o <= (state == ST_HOLD) & ~rel & i2c_on;
      irq_o <= addr_hit | rx_done | tx_done | to_ovf;
      wake_o <= addr_hit & status.address_wake_enable;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
    start && !to_ovf && !en_rise |=> status.bus_busy_flag) else $error("busy flag not set by start");
  a_busy_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    stop && !en_rise && !start |=> !status.bus_busy_flag) else $error("busy flag not cleared by stop");
  a_match_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    addr_hit && !to_ovf |=> status.address_match_flag && irq_o) else $error("match without flag or irq");
  a_rw_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    addr_hit && !to_ovf |=> status.read_write_status == $past(shreg[0])) else $error("rw bit lost");
  a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_AACK && i2c_on |=> sda_oe_o) else $error("address not acknowledged");
  a_rx_complete: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_done && !to_ovf |=> status.transfer_complete_flag && irq_o ##1 state == ST_RACK || !i2c_on)
    else $error("byte completion missing");
  a_hold_scl: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_HOLD && !rel && i2c_on ##1 state == ST_HOLD |-> scl_oe_o) else $error("scl not held");
  a_nack_release: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_TACK && scl_fall && status.receive_ack_flag && i2c_on && !stop && !start && !to_ovf
    |=> state == ST_SKIP ##1 !sda_oe_o) else $error("sda kept after nack");
  a_ack_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_smp && !to_ovf && !en_rise |=> status.receive_ack_flag == $past(sda_s)) else $error("ack not sampled");
  a_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    to_ovf |=> to_flag && !to_en && !to_run && irq_o) else $error("time-out not handled");

endmodule
`default_nettype wire

// >>> verif/i2css_master_model.sv
// i2c bus master model: start, stop, byte write and byte read with clock stretching
`timescale 1ns/1ns
`default_nettype none
module i2css_master_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_dn_o,
  output logic sda_dn_o
);
  localparam int HALF = 40;

  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // both lines released, pull-ups idle them high; scl stands still outside frames
  initial
  begin
    scl_dn_o = 1'b0;
    sda_dn_o = 1'b0;
  end

  // one scl pulse, stretched while the slave holds scl low; the long low phase
  // lets the slave's sda change settle before scl rises
  task automatic pulse(output logic b);
    #HALF scl_dn_o <= 1'b0;
    wait (scl_i === 1'b1);
    #(HALF * 3 / 8) b = sda_i;
    #(HALF * 3 / 8) scl_dn_o <= 1'b1;
  endtask

  // data changes an eighth of a period after scl falls
  task automatic send_bit(input logic b);
    logic d;
    #(HALF / 4) sda_dn_o <= ~b;
    pulse(d);
  endtask

  task automatic get_bit(output logic b);
    #(HALF / 4) sda_dn_o <= 1'b0;
    pulse(b);
  endtask

  // ----------------------------------------
  // frame level
  // ----------------------------------------
  // sda falls while scl is high
  task automatic start();
    #(HALF / 4) sda_dn_o <= 1'b0;
    #(HALF / 4) scl_dn_o <= 1'b0;
    wait (scl_i === 1'b1);
    #HALF sda_dn_o <= 1'b1;
    #HALF scl_dn_o <= 1'b1;
  endtask

  // sda rises while scl is high
  task automatic stop();
    #(HALF / 4) sda_dn_o <= 1'b1;
    #(HALF * 3 / 4) scl_dn_o <= 1'b0;
    wait (scl_i === 1'b1);
    #HALF sda_dn_o <= 1'b0;
    #HALF;
  endtask

  // eight bits msb first, then the slave's acknowledge
  task automatic write_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      send_bit(b[i]);
    get_bit(ack);
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      get_bit(b[i]);
    send_bit(ack);
  endtask
endmodule
`default_nettype wire

// >>> verif/i2css_top_tb.sv
// self-checking bench of the i2c slave: wishbone registers and bus transfers
`timescale 1ns/1ns
`default_nettype none
module i2css_top_tb;
  import i2css_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, scl_oe, scl_o, sda_oe, sda_o, irq, wake, m_scl, m_sda, bit_ack;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [6:0] sa;
  logic [7:0] d0, d1, got;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_irq = 0;
  int n_wake = 0;
  int cycles = 0;
  integer seed = 32'h7a4d;
  // open-drain wires with pull-ups
  wire scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl;
  wire sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda;

  always #5 clk_i = ~clk_i;

  i2css_top #(.TO_TICK_CYCLES(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .irq_o(irq), .wake_o(wake));

  i2css_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_dn_o(m_scl), .sda_dn_o(m_sda));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x, input logic [31:0] k);
    n_compared++;
    if ((g & k) !== x)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g & k, x);
    end
  endtask

  task automatic chk_bus(input logic [7:0] g, input logic [7:0] x);
    chk_reg({24'h00_0000, g}, {24'h00_0000, x}, 32'hFFFF_FFFF);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // oldest noted read value against data on ack; pulse counts; hang limit
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      e = exp_q.pop_front();
      chk_reg(rdat, {24'h00_0000, e[7:0]}, {24'hFF_FFFF, e[15:8]});
    end
    if (irq === 1'b1)
      n_irq++;
    if (wake === 1'b1)
      n_wake++;
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // one classic wishbone cycle; reads note value and mask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] k);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    if (!w)
      exp_q.push_back({k, d});
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    sa = 7'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS_CTRL, RST_STATUS_CTRL, 8'hFF);
    wb(1'b0, OFS_MODULE_CTRL, 8'hE0, 8'hFF);
    wb(1'b1, 8'h14, 8'h5A, 8'h00);
    wb(1'b0, 8'h14, 8'h00, 8'hFF);
    wb(1'b1, OFS_MODULE_CTRL, {MODE_I2C_SLAVE, 5'h02}, 8'h00);
    wb(1'b1, OFS_SLAVE_ADDR, {sa, 1'b1}, 8'h00);
    wb(1'b0, OFS_SLAVE_ADDR, {sa, 1'b0}, 8'hFF);
    $display("test registers done");
    m.start();
    m.write_byte({sa ^ 7'h01, 1'b0}, bit_ack);
    chk_bus(8'(bit_ack), 8'h01);
    wb(1'b0, OFS_STATUS_CTRL, 8'h20, 8'h60);
    m.stop();
    wb(1'b0, OFS_STATUS_CTRL, 8'h00, 8'h20);
    $display("test foreign address done");
    m.start();
    m.write_byte({sa, 1'b0}, bit_ack);
    chk_bus(8'(bit_ack), 8'h00);
    wb(1'b0, OFS_STATUS_CTRL, 8'hE1, 8'hFF);
    // scl hold is registered a few cycles after the ninth fall
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bus(8'(scl_oe), 8'h01);
    wb(1'b1, OFS_STATUS_CTRL, 8'h00, 8'h00);
    wb(1'b0, OFS_DATA, 8'h00, 8'h00);
    repeat (2) @(posedge clk_i);
    chk_bus(8'(scl_oe), 8'h00);
    m.write_byte(d0, bit_ack);
    chk_bus(8'(bit_ack), 8'h00);
    wb(1'b0, OFS_STATUS_CTRL, 8'hA0, 8'hE4);
    wb(1'b1, OFS_STATUS_CTRL, 8'h08, 8'h00);
    wb(1'b0, OFS_DATA, d0, 8'hFF);
    m.write_byte(d1, bit_ack);
    chk_bus(8'(bit_ack), 8'h01);
    wb(1'b1, OFS_STATUS_CTRL, 8'h00, 8'h00);
    wb(1'b0, OFS_DATA, d1, 8'hFF);
    m.stop();
    wb(1'b0, OFS_STATUS_CTRL, 8'h00, 8'h20);
    $display("test slave receive done");
    wb(1'b1, OFS_STATUS_CTRL, 8'h18, 8'h00);
    // leave the busy flag set so the enable edge has something to clear
    m.start();
    wb(1'b1, OFS_MODULE_CTRL, {MODE_I2C_SLAVE, 5'h00}, 8'h00);
    wb(1'b1, OFS_MODULE_CTRL, {MODE_I2C_SLAVE, 5'h02}, 8'h00);
    wb(1'b0, OFS_STATUS_CTRL, 8'h99, 8'hFF);
    m.stop();
    wb(1'b1, OFS_STATUS_CTRL, 8'h02, 8'h00);
    $display("test enable edge done");
    m.start();
    m.write_byte({sa, 1'b1}, bit_ack);
    chk_bus(8'(bit_ack), 8'h00);
    wb(1'b0, OFS_STATUS_CTRL, 8'hC6, 8'hC6);
    wb(1'b1, OFS_STATUS_CTRL, 8'h10, 8'h00);
    wb(1'b1, OFS_DATA, d1, 8'h00);
    m.read_byte(1'b0, got);
    chk_bus(got, d1);
    wb(1'b0, OFS_STATUS_CTRL, 8'h80, 8'h81);
    wb(1'b1, OFS_DATA, d0, 8'h00);
    m.read_byte(1'b1, got);
    chk_bus(got, d0);
    wb(1'b0, OFS_STATUS_CTRL, 8'h01, 8'h01);
    chk_bus(8'(sda_oe), 8'h00);
    m.stop();
    wb(1'b0, OFS_STATUS_CTRL, 8'h00, 8'h20);
    $display("test slave transmit done");
    wb(1'b1, OFS_TIMEOUT_CTRL, 8'h80, 8'h00);
    m.start();
    repeat (100) @(posedge clk_i);
    wb(1'b0, OFS_TIMEOUT_CTRL, 8'h40, 8'hFF);
    wb(1'b0, OFS_STATUS_CTRL, RST_STATUS_CTRL, 8'hFF);
    m.stop();
    chk_bus(8'(n_irq), 8'h07);
    chk_bus(8'(n_wake), 8'h01);
    $display("test time-out done");
    end_sim();
  end
endmodule
`default_nettype wire
